// ==== adc_device.sv ====
// Converter end: address capture, sampling, conversion and serial result output.
// Contract
// RL1: Fast chip-select-high mode uses ten clocks.
// RL2: Chip select fall enables the result output.
// RL3: Chip select rise floats output, ends sequence.
// RL4: Inputs ignored shortly after chip select rises.
// RL5: Done flag rise starts sequence, shows MSB.
// RL6: Extended high-between mode allows 11 to 16.
// RL7: Continuous low extended modes need sixteen clocks.
// RL8: Slow modes need eleventh edge before done.
// RL9: Eleventh rise within 9.5 us of tenth.
// RL10: Slow continuous mode restarts at sixteenth fall.
// RL11: Four address bits, MSB first, rising edges.
// RL12: Codes zero to ten pick external inputs.
// RL13: Codes eleven to thirteen pick reference levels.
// RL14: Sampling from fourth to tenth falling edge.
// RL15: Successive approximation, MSB first, weight 512.
// RL16: Chip select fall aborts, keeps old result.
// RL17: Avoid chip select fall near conversion end.
// RL18: Result saturates at full scale and zero.
// RL19: Conversion ending first means slow-mode handling.
// RL20: Done flag low at tenth, high when ready.
// RL21: Output forced low from the tenth fall.
// RL22: Nine remaining bits on following falling edges.
// RL23: Conversion length is a parameter.
// RL24: Codes fourteen and fifteen give undefined results.
`timescale 1ns/1ps
module adc_device #(
	parameter int CONV_CYCLES = adc_link_pkg::CONV_CYCLES, // Conversion length in link clock cycles.
	parameter int IN_BITS     = 12                         // Width of each analog input sample.
) (
	input  wire logic                clk_link,   // Internal converter clock.
	input  wire logic                rst,        // Asynchronous reset, active high.
	adc_link_if.device               link,       // Serial pins.
	input  wire logic [IN_BITS-1:0]  analog_input_zero,      // External input 0.
	input  wire logic [IN_BITS-1:0]  analog_input_one,       // External input 1.
	input  wire logic [IN_BITS-1:0]  analog_input_two,       // External input 2.
	input  wire logic [IN_BITS-1:0]  analog_input_three,     // External input 3.
	input  wire logic [IN_BITS-1:0]  analog_input_four,      // External input 4.
	input  wire logic [IN_BITS-1:0]  analog_input_five,      // External input 5.
	input  wire logic [IN_BITS-1:0]  analog_input_six,       // External input 6.
	input  wire logic [IN_BITS-1:0]  analog_input_seven,     // External input 7.
	input  wire logic [IN_BITS-1:0]  analog_input_eight,     // External input 8.
	input  wire logic [IN_BITS-1:0]  analog_input_nine,      // External input 9.
	input  wire logic [IN_BITS-1:0]  analog_input_ten,       // External input 10.
	input  wire logic [IN_BITS-1:0]  ref_low,                // Lower reference level.
	input  wire logic [IN_BITS-1:0]  ref_high,               // Upper reference level.
	output logic                     busy                    // High while a conversion runs.
);

	// ==========================================================
	// Types and state.
	// ==========================================================
	typedef enum logic [1:0] {
		PH_IDLE   = 2'b00, // Waiting for chip select.
		PH_XFER   = 2'b01, // Serial transfer running.
		PH_CONV   = 2'b10, // Conversion running.
		PH_LOST   = 2'b11  // Synchronization lost; falls back to idle on the next cycle.
	} phase_t;

	typedef struct packed {
		logic [2:0]             cs_sync;   // Chip select synchroniser and edge stage.
		logic [2:0]             ck_sync;   // Shift clock synchroniser and edge stage.
		logic [1:0]             ad_sync;   // Address synchroniser.
		logic [1:0]             guard;     // Edges waited after chip select falls.
		phase_t                 phase;     // Sequence phase.
		logic [4:0]             nclk;      // Falling edges seen in this transfer.
		logic [3:0]             addr_sh;   // Address being shifted in.
		logic [3:0]             chan;      // Channel used for the conversion.
		logic [IN_BITS-1:0]     sample;    // Held sample.
		logic [IN_BITS-1:0]     lo_hold;   // Held lower reference.
		logic [IN_BITS-1:0]     hi_hold;   // Held upper reference.
		logic [9:0]             result;    // Output data register.
		logic [9:0]             sar;       // Trial register.
		logic [9:0]             weight;    // Current trial weight.
		logic [7:0]             ccnt;      // Conversion cycle counter.
		logic [9:0]             shift;     // Serial output shift register.
		logic                   oe;        // Result pin driven.
		logic                   eoc;       // Conversion done flag.
		logic                   slow;      // Conversion ended before the transfer.
	} state_t;

	state_t s_q;  // Registered state.
	state_t s_d;  // Next state.

	// Scales a sample into the ten-bit code range relative to the references.
	function automatic logic [9:0] scale(input logic [IN_BITS-1:0] v, input logic [IN_BITS-1:0] lo,
		input logic [IN_BITS-1:0] hi);
		logic [IN_BITS+10:0] num;
		logic [IN_BITS:0]    span;
		logic [IN_BITS+10:0] q;
		num  = '0;
		span = '0;
		q    = '0;
		if (v >= hi) begin
			scale = adc_link_pkg::CODE_FULL;                                  // [RL18]
		end else if (v <= lo) begin
			scale = adc_link_pkg::CODE_ZERO;                                  // [RL18]
		end else begin
			num   = (IN_BITS+11)'(v - lo) << 10;
			span  = (IN_BITS+1)'(hi - lo);
			q     = num / (IN_BITS+11)'(span);
			scale = q[9:0];
		end
	endfunction

	// Selects a source sample for an address code.
	function automatic logic [IN_BITS-1:0] pick(input logic [3:0] a, input logic [IN_BITS-1:0] lo,
		input logic [IN_BITS-1:0] hi);
		case (a)
			4'h0: pick = analog_input_zero;                                   // [RL12]
			4'h1: pick = analog_input_one;
			4'h2: pick = analog_input_two;
			4'h3: pick = analog_input_three;
			4'h4: pick = analog_input_four;
			4'h5: pick = analog_input_five;
			4'h6: pick = analog_input_six;
			4'h7: pick = analog_input_seven;
			4'h8: pick = analog_input_eight;
			4'h9: pick = analog_input_nine;
			4'ha: pick = analog_input_ten;                                    // [RL12]
			adc_link_pkg::ADDR_MID:  pick = IN_BITS'(({1'b0, lo} + {1'b0, hi} + 1'b1) >> 1); // [RL13]
			adc_link_pkg::ADDR_LOW:  pick = lo;                               // [RL13]
			adc_link_pkg::ADDR_HIGH: pick = hi;                               // [RL13]
			default: pick = lo;                                               // [RL24]
		endcase
	endfunction

	logic cs_fall;  // Synchronised chip select falling edge.
	logic cs_rise;  // Synchronised chip select rising edge.
	logic ck_rise;  // Synchronised shift clock rising edge.
	logic ck_fall;  // Synchronised shift clock falling edge.
	logic trial;    // Current trial level.

	// ==========================================================
	// Next-state logic.
	// ==========================================================
	always_comb begin
		s_d     = s_q;
		cs_fall = s_q.cs_sync[2] & ~s_q.cs_sync[1];
		cs_rise = ~s_q.cs_sync[2] & s_q.cs_sync[1];
		ck_rise = ~s_q.ck_sync[2] & s_q.ck_sync[1];
		ck_fall = s_q.ck_sync[2] & ~s_q.ck_sync[1];
		trial   = 1'b0;
		// Pins pass two flip-flops before any logic reads them.
		s_d.cs_sync = {s_q.cs_sync[1:0], link.cs_n};
		s_d.ck_sync = {s_q.ck_sync[1:0], link.sclk};
		s_d.ad_sync = {s_q.ad_sync[0], link.addr};

		if (cs_rise) begin
			// End the sequence and float the pin; a running conversion still finishes.
			s_d.oe    = 1'b0;                                                 // [RL3]
			s_d.guard = '0;
			if (s_q.phase != PH_CONV) begin
				s_d.phase = PH_IDLE;                                          // [RL4]
			end
		end else if (cs_fall) begin
			// A new falling edge aborts any cycle; the old result stays put.
			s_d.phase  = PH_XFER;                                             // [RL16]
			s_d.nclk   = '0;
			s_d.guard  = '0;
			s_d.oe     = 1'b1;                                                // [RL2]
			s_d.eoc    = 1'b1;
			s_d.shift  = s_q.result;                                          // [RL16]
			s_d.slow   = 1'b0;
		end else begin
			case (s_q.phase)
				PH_IDLE: begin
					// Clock and address are ignored while deselected.
				end
				PH_XFER, PH_CONV: begin
					if (s_q.guard != 2'(adc_link_pkg::CS_GUARD_CYC)) begin
						s_d.guard = s_q.guard + 2'd1;
					end else if (!s_q.cs_sync[1]) begin                            // [RL4]
						if (ck_rise && s_q.nclk < adc_link_pkg::CLK_ADDR_LAST) begin
							s_d.addr_sh = {s_q.addr_sh[2:0], s_q.ad_sync[1]};    // [RL11]
						end
						if (ck_rise && s_q.phase == PH_CONV && s_q.nclk == adc_link_pkg::CLK_CONV_START) begin
							// Eleventh rise before the conversion ends: the transfer outlasts it.
							s_d.slow = 1'b1;                                     // [RL8]
						end
						if (ck_fall && s_q.nclk < adc_link_pkg::CLK_LONG) begin
							s_d.nclk  = s_q.nclk + 5'd1;
							s_d.shift = {s_q.shift[8:0], 1'b0};                   // [RL22]
							if (s_q.nclk == 5'd3) begin
								s_d.chan = s_q.addr_sh;                           // [RL14]
							end
							if (s_q.nclk + 5'd1 == adc_link_pkg::CLK_CONV_START) begin
								// Hold the sample and hand over to the converter.
								s_d.sample  = pick(s_q.chan, ref_low, ref_high);  // [RL14]
								s_d.lo_hold = ref_low;
								s_d.hi_hold = ref_high;
								s_d.eoc     = 1'b0;                               // [RL20]
								s_d.shift   = '0;                                 // [RL21]
								s_d.phase   = PH_CONV;
								s_d.sar     = '0;
								s_d.weight  = adc_link_pkg::CODE_MID;             // [RL15]
								s_d.ccnt    = '0;
							end
							if (s_q.slow && s_q.phase == PH_XFER && s_q.nclk + 5'd1 == adc_link_pkg::CLK_LONG) begin
								// Continuous-select slow mode restarts at the sixteenth fall.
								s_d.shift = s_q.result;                           // [RL10]
								s_d.nclk  = '0;
								s_d.slow  = 1'b0;
							end
						end
					end
					if (s_q.phase == PH_CONV) begin
						// Convert one trial per link clock, MSB first.
						s_d.ccnt = s_q.ccnt + 8'd1;                               // [RL23]
						if (s_q.weight != '0) begin
							trial      = (scale(s_q.sample, s_q.lo_hold, s_q.hi_hold) >= (s_q.sar | s_q.weight));
							s_d.sar    = trial ? (s_q.sar | s_q.weight) : s_q.sar; // [RL15]
							s_d.weight = s_q.weight >> 1;
						end
						if (s_q.ccnt >= 8'(CONV_CYCLES - 1)) begin
							s_d.result = s_q.sar;
							s_d.eoc    = 1'b1;                                    // [RL20]
							s_d.slow   = 1'b0;
							if (s_q.cs_sync[1]) begin
								// Deselected during the conversion: wait for the next select.
								s_d.phase = PH_IDLE;                              // [RL3]
							end else if (!s_q.slow || s_q.nclk == adc_link_pkg::CLK_LONG) begin
								// Transfer already over: the done flag rise starts the next sequence.
								s_d.phase = PH_XFER;
								s_d.nclk  = '0;
								s_d.shift = s_q.sar;                              // [RL5]
							end else begin
								// Transfer outlived the conversion: slow mode.
								s_d.phase = PH_XFER;                              // [RL19]
								s_d.slow  = 1'b1;                                 // [RL19]
							end
						end
					end
				end
				default: s_d.phase = PH_IDLE;
			endcase
		end
	end

	// ==========================================================
	// State register.
	// ==========================================================
	always_ff @(posedge clk_link or posedge rst) begin
		if (rst) begin
			s_q         <= '0;
			s_q.cs_sync <= 3'b111;
			s_q.eoc     <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Link outputs come straight from state flip-flops; busy is decoded from the phase.
	assign link.dout    = s_q.shift[9];
	assign link.dout_oe = s_q.oe;
	assign link.eoc     = s_q.eoc;
	assign busy         = (s_q.phase == PH_CONV);

endmodule

// ==== adc_link_pkg.sv ====
// Package of shared constants for the serial converter link.
package adc_link_pkg;

	// ==========================================================
	// Transfer shape.
	// ==========================================================
	localparam int          ADDR_BITS      = 4;         // Channel address width.
	localparam int          RESULT_BITS    = 10;        // Result width.
	localparam logic [4:0]  CLK_ADDR_LAST  = 5'h04;     // Last address edge count.
	localparam logic [4:0]  CLK_CONV_START = 5'h0a;     // Falling edge that starts conversion.
	localparam logic [4:0]  CLK_LONG       = 5'h10;     // Clock count of an extended transfer.
	localparam logic [4:0]  CLK_MIN_SLOW   = 5'h0b;     // Least clock count in a slow mode.
	localparam logic [4:0]  CLK_SHORT      = 5'h0a;     // Clock count of a short transfer.

	// ==========================================================
	// Address map.
	// ==========================================================
	localparam logic [3:0]  ADDR_EXT_LAST  = 4'h0a;     // Highest external analog input.
	localparam logic [3:0]  ADDR_MID       = 4'h0b;     // Reference midpoint.
	localparam logic [3:0]  ADDR_LOW       = 4'h0c;     // Lower reference.
	localparam logic [3:0]  ADDR_HIGH      = 4'h0d;     // Upper reference.

	// ==========================================================
	// Result codes.
	// ==========================================================
	localparam logic [9:0]  CODE_FULL      = 10'h03ff;  // Full scale.
	localparam logic [9:0]  CODE_ZERO      = 10'h0000;  // Zero scale.
	localparam logic [9:0]  CODE_MID       = 10'h0200;  // Midpoint, also first trial weight.

	// ==========================================================
	// Timing.
	// ==========================================================
	localparam int          CONV_CYCLES    = 40;        // Internal conversion length in link cycles.
	localparam int          CS_GUARD_CYC   = 2;         // Internal edges before responding to chip select.
	localparam int          HOST_DIV       = 50;        // Host half period of shift clock in sys cycles, 1 MHz clock.
	localparam int          SLOW_GAP_NS    = 9500;      // Longest gap before the eleventh rising edge.
	localparam int          SYS_PERIOD_NS  = 10;        // Host clock period.
	localparam int          SLOW_GAP_CYC   = SLOW_GAP_NS / SYS_PERIOD_NS; // Rounded down.

endpackage

// ==== adc_link_if.sv ====
// Interface joining the host serial port to the converter.
`timescale 1ns/1ps
interface adc_link_if;
	logic cs_n;           // Chip select, active low, host drives.
	logic sclk;           // Serial shift clock, host drives.
	logic addr;           // Serial channel address, host drives.
	logic dout;           // Serial result value from the device.
	logic dout_oe;        // High while the device drives its result pin.
	logic eoc;            // Conversion done flag from the device.
	logic dout_wire;      // Resolved level of the result pin.

	// The result pin floats high when nobody drives it.
	assign dout_wire = dout_oe ? dout : 1'b1;

	modport device (input cs_n, input sclk, input addr, output dout, output dout_oe, output eoc);
	modport host   (output cs_n, output sclk, output addr, input dout_wire, input eoc);
endinterface

// ==== adc_host.sv ====
// Host end: drives chip select, shift clock and address; collects results.
`timescale 1ns/1ps
module adc_host #(
	parameter int HOST_DIV   = adc_link_pkg::HOST_DIV,     // Half shift-clock period in sys cycles.
	parameter int GUARD_CYC  = 160                          // Select setup wait in sys cycles.
) (
	input  wire logic        clk_sys,      // Host clock.
	input  wire logic        rst,          // Asynchronous reset, active high.
	adc_link_if.host         link,         // Serial pins.
	input  wire logic        start,        // Pulse: begin one transfer.
	input  wire logic [3:0]  chan,         // Channel address for the next conversion.
	input  wire logic        long_xfer,    // High for a sixteen-clock transfer.
	output logic             ready,        // High when a new start is taken.
	output logic [9:0]       result,       // Previous conversion result.
	output logic             result_valid  // One-cycle pulse when result updates.
);

	// ==========================================================
	// State.
	// ==========================================================
	typedef enum logic [1:0] {
		H_IDLE  = 2'b00, // Deselected.
		H_SETUP = 2'b01, // Select setup wait.
		H_SHIFT = 2'b10, // Clocking.
		H_DONE  = 2'b11  // Deselect after transfer.
	} hphase_t;

	typedef struct packed {
		hphase_t     phase;   // Transfer phase.
		logic [1:0]  eoc_s;   // Done flag synchroniser.
		logic [1:0]  din_s;   // Result pin synchroniser.
		logic        cs_n;    // Chip select.
		logic        sclk;    // Shift clock.
		logic [3:0]  addr;    // Address being shifted out.
		logic [4:0]  nclk;    // Clocks issued.
		logic [4:0]  total;   // Clocks in this transfer.
		logic [15:0] div;     // Phase counter.
		logic [9:0]  rx;      // Received bits.
		logic [9:0]  res;     // Result register.
		logic        vld;     // Result pulse.
	} hstate_t;

	hstate_t h_q;  // Registered state.
	hstate_t h_d;  // Next state.

	// ==========================================================
	// Next-state logic.
	// ==========================================================
	always_comb begin
		h_d       = h_q;
		h_d.eoc_s = {h_q.eoc_s[0], link.eoc};
		h_d.din_s = {h_q.din_s[0], link.dout_wire};
		h_d.vld   = 1'b0;
		case (h_q.phase)
			H_IDLE: begin
				if (start) begin
					h_d.cs_n  = 1'b0;
					h_d.addr  = chan;
					h_d.nclk  = '0;
					// Ten clocks, or sixteen for an extended transfer.
					h_d.total = long_xfer ? adc_link_pkg::CLK_LONG : adc_link_pkg::CLK_SHORT; // [RL1] [RL7]
					h_d.div   = '0;
					h_d.phase = H_SETUP;
				end
			end
			H_SETUP: begin
				h_d.div = h_q.div + 16'd1;
				if (h_q.div >= 16'(GUARD_CYC)) begin
					h_d.div   = '0;
					h_d.phase = H_SHIFT;
				end
			end
			H_SHIFT: begin
				h_d.div = h_q.div + 16'd1;
				if (h_q.div >= 16'(HOST_DIV - 1)) begin
					h_d.div = '0;
					if (!h_q.sclk) begin
						// Rising edge: device takes address, host samples data.
						h_d.sclk = 1'b1;                                         // [RL11]
						if (h_q.nclk < 5'd10) begin
							h_d.rx = {h_q.rx[8:0], h_q.din_s[1]};
						end
					end else begin
						// Falling edge: present the next address bit.
						h_d.sclk = 1'b0;
						h_d.addr = {h_q.addr[2:0], 1'b0};
						h_d.nclk = h_q.nclk + 5'd1;
						if (h_q.nclk + 5'd1 == h_q.total) begin
							h_d.phase = H_DONE;                                  // [RL6] [RL9]
						end
					end
				end
			end
			H_DONE: begin
				// Select rises half a clock after the last fall, so the device sees that fall first.
				h_d.div = h_q.div + 16'd1;
				if (h_q.div == 16'(HOST_DIV - 1)) begin
					h_d.cs_n = 1'b1;
					h_d.res  = h_q.rx;
					h_d.vld  = 1'b1;
				end
				// No new select until the conversion is done, so it is never cut short.
				if (h_q.div >= 16'(GUARD_CYC) && h_q.eoc_s[1]) begin
					h_d.div   = '0;
					h_d.phase = H_IDLE;                                          // [RL17]
				end
			end
			default: h_d.phase = H_IDLE;
		endcase
	end

	// ==========================================================
	// State register.
	// ==========================================================
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			h_q      <= '0;
			h_q.cs_n <= 1'b1;
		end else begin
			h_q <= h_d;
		end
	end

	assign link.cs_n    = h_q.cs_n;
	assign link.sclk    = h_q.sclk;
	assign link.addr    = h_q.addr[3];
	assign ready        = (h_q.phase == H_IDLE);
	assign result       = h_q.res;
	assign result_valid = h_q.vld;

endmodule

// ==== adc_link_chk.sv ====
// Concurrent checks on the serial link between host and converter.
`timescale 1ns/1ps
module adc_link_chk #(
	parameter int CONV_CYCLES = adc_link_pkg::CONV_CYCLES // Conversion length in link cycles.
) (
	input wire logic clk_link, // Converter clock.
	input wire logic rst,      // Reset, active high.
	input wire logic cs_n,     // Chip select, active low.
	input wire logic sclk,     // Shift clock.
	input wire logic dout,     // Result bit.
	input wire logic dout_oe,  // Result pin enable.
	input wire logic eoc       // Conversion done flag.
);
	default clocking cb @(posedge clk_link); endclocking
	default disable iff (rst);
	// ==========================================================
	// Helper counters.
	logic [5:0] fall_cnt_q; // Link cycles since the last shift clock fall.
	logic [7:0] low_cnt_q;  // Link cycles the done flag has been low.
	logic       sclk_q;     // Shift clock one link cycle ago.
	logic       armed_q;    // High once a link edge has passed since reset.
	// Counting on the raw pins keeps the checker free of the design's synchronisers.
	always_ff @(posedge clk_link or posedge rst) begin
		if (rst) begin
			fall_cnt_q <= 6'h3f;
			low_cnt_q <= 8'h00;
			sclk_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			sclk_q <= sclk;
			armed_q <= 1'b1;
			fall_cnt_q <= (sclk_q && !sclk) ? 6'h00 : fall_cnt_q + {5'h00, fall_cnt_q != 6'h3f};
			low_cnt_q <= eoc ? 8'h00 : low_cnt_q + 8'h01;
		end
	end
	// ==========================================================
	// Select edges.
	sequence sel_fall; $fell(cs_n); endsequence
	sequence sel_rise; $rose(cs_n); endsequence
	chk_oe_on_select: assert property (sel_fall |-> ##[1:5] dout_oe)
		else $error("result pin not driven after select fell");
	chk_oe_off_release: assert property (sel_rise |-> ##[1:5] !dout_oe)
		else $error("result pin still driven after select rose");
	chk_idle_released: assert property (cs_n [*6] |-> !dout_oe)
		else $error("result pin driven while deselected");
	chk_idle_no_start: assert property (cs_n [*6] |-> !$fell(eoc))
		else $error("conversion started while deselected");
	chk_force_low: assert property ((!eoc && !$past(eoc) && dout_oe) |-> !dout)
		else $error("result pin not low during conversion");
	chk_eoc_on_fall: assert property ($fell(eoc) |-> fall_cnt_q <= 6'h05)
		else $error("done flag fell away from a shift clock fall");
	chk_shift_on_fall: assert property (($changed(dout) && dout_oe && $past(dout_oe) && eoc && $past(eoc))
		|-> fall_cnt_q <= 6'h05)
		else $error("result bit changed away from a shift clock fall");
	chk_conv_length: assert property (($rose(eoc) && armed_q) |-> (int'(low_cnt_q) >= CONV_CYCLES - 1))
		else $error("conversion finished too early");
	chk_conv_bound: assert property (int'(low_cnt_q) <= CONV_CYCLES + 1)
		else $error("conversion ran too long");
endmodule

// ==== serial_adc_interface_control_tb_top.sv ====
// Self-checking bench: host and converter joined over the serial link.
`timescale 1ns/1ps
module serial_adc_interface_control_tb_top;
	localparam int CONV = adc_link_pkg::CONV_CYCLES; // Long transfers outlast it and run slow.
	logic        busy;          // Converter busy flag.
	logic        clk_sys;       // Host clock, 100 MHz.
	logic        clk_link;      // Converter clock, 30 ns.
	logic        rst;           // Shared reset.
	logic        start;         // Transfer request.
	logic [3:0]  chan;          // Requested channel.
	logic        long_xfer;     // Sixteen-clock transfer.
	logic        ready;         // Host can take a request.
	logic [9:0]  result;        // Returned result.
	logic        result_valid;  // Result update pulse.
	logic [12:0] ain [0:10];    // External input levels.
	logic [12:0] ref_low;       // Lower reference.
	logic [12:0] ref_high;      // Upper reference.
	logic [31:0] seed;          // Random state.
	int          mismatches;    // Failed comparisons.
	int          cmp_count;     // Comparisons made.
	logic [9:0]  exp_q;         // Expected code of the conversion in flight.
	logic        mid_q;         // That conversion was the midpoint.
	adc_link_if link_i();
	adc_host adc_host_i (.clk_sys(clk_sys), .rst(rst), .link(link_i.host), .start(start), .chan(chan),
		.long_xfer(long_xfer), .ready(ready), .result(result), .result_valid(result_valid));
	adc_device #(.CONV_CYCLES(CONV), .IN_BITS(13)) adc_device_i (.clk_link(clk_link), .rst(rst),
		.link(link_i.device), .analog_input_zero(ain[0]), .analog_input_one(ain[1]), .analog_input_two(ain[2]),
		.analog_input_three(ain[3]), .analog_input_four(ain[4]), .analog_input_five(ain[5]),
		.analog_input_six(ain[6]), .analog_input_seven(ain[7]), .analog_input_eight(ain[8]),
		.analog_input_nine(ain[9]), .analog_input_ten(ain[10]), .ref_low(ref_low), .ref_high(ref_high),
		.busy(busy));
	adc_link_chk #(.CONV_CYCLES(CONV)) adc_link_chk_i (.clk_link(clk_link), .rst(rst), .cs_n(link_i.cs_n),
		.sclk(link_i.sclk), .dout(link_i.dout), .dout_oe(link_i.dout_oe), .eoc(link_i.eoc));
	// Host clock toggles every half period; the link clock runs with an unrelated phase.
	always #5 clk_sys = ~clk_sys;
	initial begin
		clk_link = 1'b0;
		#7;
		forever #15 clk_link = ~clk_link;
	end
	// Xorshift step for repeatable random values.
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Ideal code of one channel, saturating at both references.
	function automatic logic [9:0] expect_code(input logic [3:0] c);
		if (c > adc_link_pkg::ADDR_EXT_LAST) begin
			return (c == adc_link_pkg::ADDR_MID) ? adc_link_pkg::CODE_MID :
				(c == adc_link_pkg::ADDR_HIGH) ? adc_link_pkg::CODE_FULL : adc_link_pkg::CODE_ZERO;
		end
		if (ain[c] >= ref_high) return adc_link_pkg::CODE_FULL;
		if (ain[c] <= ref_low) return adc_link_pkg::CODE_ZERO;
		return 10'((int'(ain[c] - ref_low) << 10) / int'(ref_high - ref_low));
	endfunction
	// Compares one code; the midpoint may land one step low on an exact trip.
	task automatic check(input logic [9:0] got, input logic [9:0] want, input logic alt);
		cmp_count++;
		if (got !== want && !(alt && got === want - 10'h001)) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	// Prints the verdict and ends the run.
	task automatic stop_test();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Waits, bounded, for ready or for the result pulse.
	task automatic wait_high(input logic want_valid);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while ((want_valid ? result_valid : ready) !== 1'b1 && n < 4000);
		if (n >= 4000) begin
			mismatches++;
			stop_test();
		end
	endtask
	// Every address code first, then random channels and transfer lengths.
	initial begin
		clk_sys = 1'b0;
		seed = 32'hdaf4_ff1e;
		mismatches = 0;
		cmp_count = 0;
		rst = 1'b1;
		start = 1'b0;
		chan = 4'h0;
		long_xfer = 1'b0;
		ref_low = 13'h0000;
		ref_high = 13'h1000;
		exp_q = 10'h000;
		mid_q = 1'b0;
		for (int j = 0; j <= 10; j++) begin
			ain[j] = 13'h0002;
		end
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 48; i++) begin
			wait_high(1'b0);
			check({9'h000, busy}, 10'h000, 1'b0);
			seed = xs(seed);
			@(posedge clk_sys);
			start <= 1'b1;
			chan <= (i < 16) ? 4'(i) : seed[3:0];
			long_xfer <= (i < 16) ? i[1] : seed[4];
			@(posedge clk_sys);
			start <= 1'b0;
			wait_high(1'b1);
			if (i > 0) begin
				check(result, exp_q, mid_q);
			end
			exp_q = expect_code(chan);
			mid_q = (chan == adc_link_pkg::ADDR_MID);
			@(posedge clk_sys);
			for (int j = 1; j <= 9; j++) begin
				seed = xs(seed);
				ain[j] <= {1'b0, seed[9:0], 2'b10};
			end
			ain[0] <= i[0] ? 13'h1fff : 13'h1000;
			ain[10] <= 13'h0000;
		end
		stop_test();
	end
endmodule
